// *** rtl/pd_pkg.sv ***
// Constants shared by the power-down and hold control block.
// Assumes a 50 MHz hclk and an AHB-Lite master with 32-bit data.
`default_nettype none
package pd_pkg;
  // Number of macrocells and pin lanes.
  localparam int LANES = 64;
  // Register byte offsets.
  localparam logic [7:0] OFF_CTRL = 8'h00;
  localparam logic [7:0] OFF_OE_LO = 8'h04;
  localparam logic [7:0] OFF_OE_HI = 8'h08;
  localparam logic [7:0] OFF_RP_LO = 8'h0c;
  localparam logic [7:0] OFF_RP_HI = 8'h10;
  localparam logic [7:0] OFF_STATUS = 8'h14;
  localparam logic [7:0] OFF_STATE_LO = 8'h18;
  localparam logic [7:0] OFF_STATE_HI = 8'h1c;
  // Control register field positions.
  localparam int CTRL_PD_EN = 0;
  localparam int CTRL_ASSIGN_A = 1;
  localparam int CTRL_ASSIGN_B = 2;
  localparam int CTRL_STBY_EN = 3;
  localparam int CTRL_W = 4;
  // Status register field positions.
  localparam int ST_PD = 0;
  localparam int ST_STBY = 1;
  localparam int ST_PIN_A = 2;
  localparam int ST_PIN_B = 3;
  // Reset values.
  localparam logic [3:0] CTRL_RST = 4'h0;
  localparam logic [31:0] WORD_RST = 32'h0000_0000;
  // Lanes whose pads double as the two power-down inputs.
  localparam int PD_A_LANE = 0;
  localparam int PD_B_LANE = 1;
  // Quiet time before standby, and the clock period, in ns.
  localparam int STBY_IDLE_NS = 200;
  localparam int CLK_NS = 20;
  localparam int STBY_IDLE_CYC = (STBY_IDLE_NS + CLK_NS - 1) / CLK_NS;
  localparam logic [3:0] STBY_MAX = 4'(STBY_IDLE_CYC);
endpackage : pd_pkg
`default_nettype wire

// *** rtl/pd_sync.sv ***
// Two flip-flop synchroniser for a bus of independent level signals.
// Assumes each bit is a slow level; no word coherence is promised.
`default_nettype none
module pd_sync #(
  parameter int W = 1
) (
  // Clock and reset.
  input wire logic hclk,
  input wire logic hresetn,
  // Asynchronous levels in, synchronised levels out.
  input wire logic [W-1:0] d,
  output logic [W-1:0] q
);
  // The first stage is read only by the second stage.
  logic [W-1:0] meta_q;

  // Both stages reset to zero so a pin reads low until sampled.
  always_ff @(posedge hclk or negedge hresetn) begin
    if (!hresetn) begin
      meta_q <= '0;
      q <= '0;
    end else begin
      meta_q <= d;
      q <= meta_q;
    end
  end
endmodule : pd_sync
`default_nettype wire

// *** rtl/pd_hold_ctrl.sv ***
// Power-down, hold and standby control for a 64-macrocell logic array.
// Assumes pins are asynchronous and an AHB-Lite master owns the registers.
//
// Summary of operation
// - Enabled option: either assigned pin high powers down.
// - Pin A, pin B or both assignable.
// - Power-down holds internal state and enabled outputs.
// - Pin changes ignored until power-down pin low.
// - Assigned pin is neither logic input nor output.
// - Reserved macrocell still makes buried logic.
// - Standby entered automatically when logic quiet.
// - Per-macrocell reduced-power bit, sixty-four bits.
`default_nettype none
module pd_hold_ctrl (
  // Clock and reset.
  input wire logic hclk,
  input wire logic hresetn,
  // AHB-Lite slave.
  input wire logic hsel,
  input wire logic [31:0] haddr,
  input wire logic [1:0] htrans,
  input wire logic hwrite,
  input wire logic [2:0] hsize,
  input wire logic [31:0] hwdata,
  input wire logic hready,
  output logic [31:0] hrdata,
  output logic hreadyout,
  output logic hresp,
  // Power-down pins.
  input wire logic power_down_input_a,
  input wire logic power_down_input_b,
  // Logic pins: low output enable means driven.
  input wire logic [63:0] pin_in,
  output logic [63:0] pin_out,
  output logic [63:0] pin_oe_n,
  // Array state and power controls.
  output logic [63:0] buried_fb,
  output logic [63:0] reduced_power,
  output logic standby,
  output logic powered_down
);
  // Lanes that become power-down pins when the feature is on.
  function automatic logic [63:0] reserved_lanes(input logic en,
                                                input logic a,
                                                input logic b);
    logic [63:0] m;
    m = '0;
    m[pd_pkg::PD_A_LANE] = en & a;
    m[pd_pkg::PD_B_LANE] = en & b;
    return m;
  endfunction : reserved_lanes

  // Register storage.
  logic [3:0] ctrl_q;
  logic [63:0] oe_en_q;
  logic [63:0] rp_q;
  // Bus bookkeeping.
  logic wr_pend_q;
  logic [7:0] waddr_q;
  logic [31:0] hrdata_q;
  // Array state.
  logic [63:0] mc_q;
  logic [63:0] pin_out_q;
  logic [63:0] pin_oe_n_q;
  logic [63:0] pin_prev_q;
  logic pd_q;
  logic standby_q;
  logic [3:0] idle_q;
  // Synchronised pins.
  logic [63:0] pin_s;
  logic [1:0] pd_s;

  // Pins cross into hclk through two flip-flops each.
  pd_sync #(.W(64)) u_pin_sync (
    .hclk(hclk),
    .hresetn(hresetn),
    .d(pin_in),
    .q(pin_s)
  );
  pd_sync #(.W(2)) u_pd_sync (
    .hclk(hclk),
    .hresetn(hresetn),
    .d({power_down_input_b, power_down_input_a}),
    .q(pd_s)
  );

  // Control decode.
  wire pd_en = ctrl_q[pd_pkg::CTRL_PD_EN];
  wire asg_a = ctrl_q[pd_pkg::CTRL_ASSIGN_A];
  wire asg_b = ctrl_q[pd_pkg::CTRL_ASSIGN_B];
  wire stby_en = ctrl_q[pd_pkg::CTRL_STBY_EN];
  // Either assigned pin high freezes the array.
  wire pd_req = pd_en & ((asg_a & pd_s[0]) | (asg_b & pd_s[1]));
  // Reserved pads feed no logic and drive nothing.
  wire [63:0] rsv = reserved_lanes(pd_en, asg_a, asg_b);
  wire [63:0] logic_in = pin_s & ~rsv;

  // Macrocell next state: pin-fed cells follow their pin, a reserved
  // cell builds a buried term from the cells two and three places above it.
  logic [63:0] mc_next;
  for (genvar i = 0; i < 64; i++) begin : g_mc
    assign mc_next[i] = rsv[i] ? (mc_q[(i + 2) % 64] & mc_q[(i + 3) % 64])
                               : logic_in[i];
  end

  // Activity is any pin change or any pending state change.
  wire activity = (pin_s != pin_prev_q) | (mc_next != mc_q);
  wire [3:0] idle_d = activity ? 4'h0 :
                      (idle_q == pd_pkg::STBY_MAX) ? idle_q : idle_q + 4'h1;
  // Standby after a quiet stretch; any change wakes it.
  wire standby_d = stby_en & ~activity & (idle_q == pd_pkg::STBY_MAX);

  // While frozen nothing moves; on release the held state carries on.
  // No reset is applied on the way out.
  always_ff @(posedge hclk or negedge hresetn) begin
    if (!hresetn) begin
      mc_q <= '0;
      pin_out_q <= '0;
      pin_oe_n_q <= '1;
    end else if (!pd_req) begin
      mc_q <= mc_next;
      pin_out_q <= mc_q & ~rsv;
      pin_oe_n_q <= ~(oe_en_q & ~rsv);
    end
  end

  // Status flops and the quiet counter.
  always_ff @(posedge hclk or negedge hresetn) begin
    if (!hresetn) begin
      pd_q <= 1'b0;
      standby_q <= 1'b0;
      idle_q <= 4'h0;
      pin_prev_q <= '0;
    end else begin
      pd_q <= pd_req;
      standby_q <= standby_d;
      idle_q <= idle_d;
      pin_prev_q <= pin_s;
    end
  end

  // Bus decode: a request is taken when selected, ready and NONSEQ/SEQ.
  wire take = hsel & hready & htrans[1];
  wire [7:0] raddr = haddr[7:0];
  wire [31:0] status_w = {28'h0, pd_s[1], pd_s[0], standby_q, pd_q};
  // Unmapped offsets read as zero.
  wire [31:0] rd_mux =
    (raddr == pd_pkg::OFF_CTRL) ? {28'h0, ctrl_q} :
    (raddr == pd_pkg::OFF_OE_LO) ? oe_en_q[31:0] :
    (raddr == pd_pkg::OFF_OE_HI) ? oe_en_q[63:32] :
    (raddr == pd_pkg::OFF_RP_LO) ? rp_q[31:0] :
    (raddr == pd_pkg::OFF_RP_HI) ? rp_q[63:32] :
    (raddr == pd_pkg::OFF_STATUS) ? status_w :
    (raddr == pd_pkg::OFF_STATE_LO) ? mc_q[31:0] :
    (raddr == pd_pkg::OFF_STATE_HI) ? mc_q[63:32] : pd_pkg::WORD_RST;

  // Address phase capture; read data is loaded so it stands in the
  // data phase. Zero wait states, so hreadyout stays high.
  always_ff @(posedge hclk or negedge hresetn) begin
    if (!hresetn) begin
      wr_pend_q <= 1'b0;
      waddr_q <= 8'h00;
      hrdata_q <= pd_pkg::WORD_RST;
    end else begin
      wr_pend_q <= take & hwrite;
      waddr_q <= raddr;
      if (take && !hwrite) begin
        hrdata_q <= rd_mux;
      end
    end
  end

  // Data phase writes. The bus side is not frozen by power-down, since
  // only pin transitions are ignored.
  always_ff @(posedge hclk or negedge hresetn) begin
    if (!hresetn) begin
      ctrl_q <= pd_pkg::CTRL_RST;
      oe_en_q <= '0;
      rp_q <= '0;
    end else if (wr_pend_q) begin
      case (waddr_q)
        pd_pkg::OFF_CTRL: ctrl_q <= hwdata[3:0];
        pd_pkg::OFF_OE_LO: oe_en_q[31:0] <= hwdata;
        pd_pkg::OFF_OE_HI: oe_en_q[63:32] <= hwdata;
        pd_pkg::OFF_RP_LO: rp_q[31:0] <= hwdata;
        pd_pkg::OFF_RP_HI: rp_q[63:32] <= hwdata;
        default: ctrl_q <= ctrl_q;
      endcase
    end
  end

  // Port drive from flip-flops; hreadyout and hresp are tied constants.
  assign hrdata = hrdata_q;
  assign hreadyout = 1'b1;
  assign hresp = 1'b0;
  assign pin_out = pin_out_q;
  assign pin_oe_n = pin_oe_n_q;
  assign buried_fb = mc_q;
  assign reduced_power = rp_q;
  assign standby = standby_q;
  assign powered_down = pd_q;

  // Checks.
  property p_pd_entry;
    @(posedge hclk) disable iff (!hresetn)
    pd_en && asg_a && pd_s[0] |=> powered_down;
  endproperty
  a_pd_entry: assert property (p_pd_entry)
    else $error("assigned pin high did not power down");

  property p_assign_only;
    @(posedge hclk) disable iff (!hresetn)
    !(asg_a && pd_s[0]) && !(asg_b && pd_s[1]) |=> !powered_down;
  endproperty
  a_assign_only: assert property (p_assign_only)
    else $error("power-down from an unassigned pin");

  property p_hold_state;
    @(posedge hclk) disable iff (!hresetn)
    pd_req |=> mc_q == $past(mc_q);
  endproperty
  a_hold_state: assert property (p_hold_state)
    else $error("internal state moved while powered down");

  property p_hold_pins;
    @(posedge hclk) disable iff (!hresetn)
    pd_req [*2] |=> $stable(pin_out) && $stable(pin_oe_n);
  endproperty
  a_hold_pins: assert property (p_hold_pins)
    else $error("outputs moved while powered down");

  property p_ignore_pins;
    @(posedge hclk) disable iff (!hresetn)
    pd_req && (pin_s != pin_prev_q) |=> $stable(buried_fb);
  endproperty
  a_ignore_pins: assert property (p_ignore_pins)
    else $error("pin change acted on during power-down");

  property p_reserved_pad;
    @(posedge hclk) disable iff (!hresetn)
    !pd_req && rsv[pd_pkg::PD_A_LANE]
      |=> pin_oe_n[pd_pkg::PD_A_LANE] && !pin_out[pd_pkg::PD_A_LANE];
  endproperty
  a_reserved_pad: assert property (p_reserved_pad)
    else $error("reserved pad driven as logic output");

  property p_buried;
    @(posedge hclk) disable iff (!hresetn)
    !pd_req && rsv[pd_pkg::PD_A_LANE]
      |=> mc_q[pd_pkg::PD_A_LANE] == $past(mc_q[2] & mc_q[3]);
  endproperty
  a_buried: assert property (p_buried)
    else $error("reserved macrocell lost its buried term");

  property p_standby;
    @(posedge hclk) disable iff (!hresetn)
    (stby_en && !activity) [*8] ##1 (stby_en && !activity) [*3]
      |=> standby;
  endproperty
  a_standby: assert property (p_standby)
    else $error("no standby after quiet stretch");

  property p_standby_off;
    @(posedge hclk) disable iff (!hresetn)
    !stby_en || activity |=> !standby;
  endproperty
  a_standby_off: assert property (p_standby_off)
    else $error("standby while disabled or busy");

  property p_rp_bits;
    @(posedge hclk) disable iff (!hresetn)
    wr_pend_q && waddr_q == pd_pkg::OFF_RP_HI
      |=> reduced_power[63:32] == $past(hwdata);
  endproperty
  a_rp_bits: assert property (p_rp_bits)
    else $error("reduced-power bits not written");

  property p_resume;
    @(posedge hclk) disable iff (!hresetn)
    $past(pd_req) && !pd_req |=> mc_q == $past(mc_next);
  endproperty
  a_resume: assert property (p_resume)
    else $error("state not resumed after power-down");

  c_pd: cover property (@(posedge hclk) disable iff (!hresetn)
    $rose(powered_down));
  c_resume: cover property (@(posedge hclk) disable iff (!hresetn)
    $fell(powered_down));
  c_standby: cover property (@(posedge hclk) disable iff (!hresetn)
    $rose(standby));
endmodule : pd_hold_ctrl
`default_nettype wire

// *** tb/pd_pin_driver.sv ***
// Model of the system logic that drives the two power-down pins.
// Assumes the bench asks for pin levels on wants sampled at hclk.
`default_nettype none
module pd_pin_driver (
  // Clock and reset.
  input wire logic hclk,
  input wire logic hresetn,
  // Requests from the bench; slow delays pin B by three cycles.
  input wire logic want_a,
  input wire logic want_b,
  input wire logic slow,
  // Pins towards the block.
  output logic power_down_input_a,
  output logic power_down_input_b
);
  timeunit 1ns;
  timeprecision 1ns;
  // Lag line, so the block also meets a sluggish far side.
  logic [2:0] lag_q;
  // Pins sit low in reset, so the block starts out running.
  always_ff @(posedge hclk or negedge hresetn) begin
    if (!hresetn) begin
      lag_q <= 3'h0;
      power_down_input_a <= 1'b0;
      power_down_input_b <= 1'b0;
    end else begin
      lag_q <= {lag_q[1:0], want_b};
      power_down_input_a <= want_a;
      power_down_input_b <= slow ? lag_q[2] : want_b;
    end
  end
endmodule : pd_pin_driver
`default_nettype wire

// *** tb/cpld_power_down_hold_control_tb.sv ***
// Self-checking bench for the power-down and hold control block.
// Assumes one bus master (this bench) and the pin driver model.
`default_nettype none
module cpld_power_down_hold_control_tb;
  timeunit 1ns;
  timeprecision 1ns;
  // Stimulus, always changed just after a rising edge.
  logic hclk = 1'b0;
  logic hresetn = 1'b0;
  logic hsel = 1'b0;
  logic [31:0] haddr = 32'h0;
  logic [1:0] htrans = 2'h0;
  logic hwrite = 1'b0;
  logic [31:0] hwdata = 32'h0;
  logic [63:0] pin_in = 64'h0;
  logic want_a = 1'b0;
  logic want_b = 1'b0;
  logic slow = 1'b0;
  // Observed outputs and the pins between model and block.
  wire logic [31:0] hrdata;
  wire logic hreadyout;
  wire logic hresp;
  wire logic pda;
  wire logic pdb;
  wire logic standby;
  wire logic powered_down;
  wire logic [63:0] pin_out;
  wire logic [63:0] pin_oe_n;
  wire logic [63:0] buried_fb;
  wire logic [63:0] reduced_power;
  // Counters and the last word read.
  int fail_count = 0;
  int checked = 0;
  logic [31:0] rd;
  always #10 hclk = ~hclk;
  pd_pin_driver far (.hclk(hclk), .hresetn(hresetn), .want_a(want_a),
    .want_b(want_b), .slow(slow), .power_down_input_a(pda),
    .power_down_input_b(pdb));
  pd_hold_ctrl dut (.hclk(hclk), .hresetn(hresetn), .hsel(hsel),
    .haddr(haddr), .htrans(htrans), .hwrite(hwrite), .hsize(3'h2),
    .hwdata(hwdata), .hready(hreadyout), .hrdata(hrdata),
    .hreadyout(hreadyout), .hresp(hresp), .power_down_input_a(pda),
    .power_down_input_b(pdb), .pin_in(pin_in), .pin_out(pin_out),
    .pin_oe_n(pin_oe_n), .buried_fb(buried_fb),
    .reduced_power(reduced_power), .standby(standby),
    .powered_down(powered_down));
  task automatic step(input int n);
    repeat (n) @(posedge hclk);
  endtask : step
  // Compares one result and counts it.
  task automatic chk(input logic [63:0] got, input logic [63:0] exp);
    checked++;
    if (got !== exp) begin
      fail_count++;
      $display("[ERR] t=%0t got=%h exp=%h", $time, got, exp);
    end
  endtask : chk
  // One single-word transfer; read data is taken at the data edge.
  task automatic bus(input logic wr, input logic [7:0] a,
                     input logic [31:0] d);
    hsel <= 1'b1;
    htrans <= 2'h2;
    haddr <= {24'h0, a};
    hwrite <= wr;
    @(posedge hclk);
    while (hreadyout !== 1'b1) @(posedge hclk);
    hsel <= 1'b0;
    htrans <= 2'h0;
    hwdata <= d;
    @(posedge hclk);
    while (hreadyout !== 1'b1) @(posedge hclk);
    rd = hrdata;
  endtask : bus
  // Reads one word and compares it; the response must be OKAY, no wait.
  task automatic rdchk(input logic [7:0] a, input logic [31:0] e);
    bus(1'b0, a, 32'h0);
    chk({32'h0, rd}, {32'h0, e});
    chk({62'h0, hresp, ~hreadyout}, 64'h0);
  endtask : rdchk
  // Reset values, read-only and unmapped places, reduced-power bits.
  task automatic t_regs();
    chk(pin_oe_n, 64'hffff_ffff_ffff_ffff);
    chk({62'h0, standby, powered_down}, 64'h0);
    rdchk(pd_pkg::OFF_CTRL, 32'h0);
    bus(1'b1, pd_pkg::OFF_RP_HI, 32'h8000_0001);
    bus(1'b1, pd_pkg::OFF_RP_LO, 32'h0000_0003);
    step(1);
    chk(reduced_power, 64'h8000_0001_0000_0003);
    rdchk(pd_pkg::OFF_RP_HI, 32'h8000_0001);
    rdchk(pd_pkg::OFF_RP_LO, 32'h0000_0003);
    bus(1'b1, pd_pkg::OFF_CTRL, 32'hffff_fff0);
    rdchk(pd_pkg::OFF_CTRL, 32'h0);
    bus(1'b1, 8'h20, 32'hffff_ffff);
    rdchk(8'h20, 32'h0);
    bus(1'b1, pd_pkg::OFF_STATUS, 32'hf);
    rdchk(pd_pkg::OFF_STATUS, 32'h0);
    $display("test regs done");
  endtask : t_regs
  // Every pin assignment, with pin B answered slowly.
  task automatic t_assign();
    logic [3:0] mode [4] = '{4'h2, 4'h3, 4'h5, 4'h7};
    slow <= 1'b1;
    foreach (mode[i]) begin
      bus(1'b1, pd_pkg::OFF_CTRL, {28'h0, mode[i]});
      want_a <= 1'b1;
      step(6);
      chk({63'h0, powered_down}, {63'h0, mode[i][0] & mode[i][1]});
      want_a <= 1'b0;
      step(6);
      chk({63'h0, powered_down}, 64'h0);
      want_b <= 1'b1;
      step(10);
      chk({63'h0, powered_down}, {63'h0, mode[i][0] & mode[i][2]});
      want_b <= 1'b0;
      step(10);
    end
    slow <= 1'b0;
    $display("test assign done");
  endtask : t_assign
  // Freeze on pin A, pin changes meanwhile, then resume.
  task automatic t_freeze();
    bus(1'b1, pd_pkg::OFF_OE_LO, 32'hffff_ffff);
    bus(1'b1, pd_pkg::OFF_OE_HI, 32'h0000_00ff);
    bus(1'b1, pd_pkg::OFF_CTRL, 32'h3);
    pin_in <= 64'h0123_4567_89ab_cdec;
    step(8);
    chk(pin_oe_n, 64'hffff_ff00_0000_0001);
    chk(buried_fb, 64'h0123_4567_89ab_cded);
    want_a <= 1'b1;
    step(6);
    pin_in <= 64'hfedc_ba98_7654_3210;
    step(8);
    chk(buried_fb, 64'h0123_4567_89ab_cded);
    chk(pin_out, 64'h0123_4567_89ab_cdec);
    rdchk(pd_pkg::OFF_STATUS, 32'h5);
    // The held macrocell state stays readable while frozen.
    rdchk(pd_pkg::OFF_STATE_LO, 32'h89ab_cded);
    rdchk(pd_pkg::OFF_STATE_HI, 32'h0123_4567);
    chk(pin_oe_n, 64'hffff_ff00_0000_0001);
    want_a <= 1'b0;
    step(8);
    chk(buried_fb, 64'hfedc_ba98_7654_3210);
    rdchk(pd_pkg::OFF_CTRL, 32'h3);
    $display("test freeze done");
  endtask : t_freeze
  // Standby comes after a quiet spell and leaves on activity.
  task automatic t_standby();
    bus(1'b1, pd_pkg::OFF_CTRL, 32'h8);
    pin_in <= 64'h0;
    step(5);
    chk({63'h0, standby}, 64'h0);
    step(15);
    chk({63'h0, standby}, 64'h1);
    pin_in <= 64'h10;
    step(6);
    chk({63'h0, standby}, 64'h0);
    $display("test standby done");
  endtask : t_standby
  task automatic give_verdict();
    $display("checked=%0d fail_count=%0d", checked, fail_count);
    if (fail_count == 0 && checked > 0) begin
      $display("ALL CHECKS OK");
    end else begin
      $display("CHECKS NOT OK");
    end
    $finish;
  endtask : give_verdict
  // Main sequence: ten cycles of reset, then the tests.
  initial begin
    repeat (10) @(posedge hclk);
    hresetn <= 1'b1;
    step(2);
    t_regs();
    t_assign();
    t_freeze();
    t_standby();
    give_verdict();
  end
  // Watchdog, far beyond the few hundred cycles the tests need.
  initial begin
    repeat (5000) @(posedge hclk);
    fail_count++;
    $display("[ERR] t=%0t got=%h exp=%h", $time, 1'b0, 1'b1);
    give_verdict();
  end
endmodule : cpld_power_down_hold_control_tb
`default_nettype wire
